// ### inc/adcf_pkg.sv
// Shared constants and carrier types of the converter status-flag block
package adcf_pkg;

  // Channel count, channel index width, result width and register address width
  localparam int ADCF_NCH = 8;
  localparam int ADCF_CHW = 3;
  localparam int ADCF_DW = 10;
  localparam int ADCF_AW = 8;

  // Register byte offsets
  localparam logic [ADCF_AW-1:0] ADCF_OFF_CTRL = 8'h00;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_MODE = 8'h04;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_CHEN = 8'h10;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_CHDIS = 8'h14;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_CHSR = 8'h18;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_STAT = 8'h1c;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_LAST = 8'h20;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_IRQ_STAT = 8'h24;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_IRQ_MASK = 8'h28;
  localparam logic [ADCF_AW-1:0] ADCF_OFF_CHAN_BASE = 8'h30;

  // Field positions
  localparam int ADCF_CTRL_START_BIT = 0;
  localparam int ADCF_MODE_SLEEP_BIT = 0;
  localparam int ADCF_STAT_CHANNEL_OVERRUN_FLAG_LSB = 8;
  localparam int ADCF_STAT_DATA_READY_FLAG_BIT = 16;
  localparam int ADCF_STAT_GENERAL_OVERRUN_FLAG_BIT = 17;
  localparam int ADCF_STAT_LOWPWR_BIT = 18;
  localparam int ADCF_LAST_CHAN_LSB = 12;

  // Interrupt event positions
  localparam int ADCF_IRQ_W = 4;
  localparam int ADCF_EV_EOC = 0;
  localparam int ADCF_EV_GENERAL_OVERRUN_FLAG = 1;
  localparam int ADCF_EV_CHANNEL_OVERRUN_FLAG = 2;
  localparam int ADCF_EV_SEQ = 3;

  // Reset values
  localparam logic [ADCF_NCH-1:0] ADCF_RST_CHEN = 8'h00;
  localparam logic [ADCF_IRQ_W-1:0] ADCF_RST_MASK = 4'h0;
  localparam logic ADCF_RST_SLEEP = 1'b0;

  // Conversion request towards the analog core
  typedef struct packed
  {
    logic valid;
    logic [ADCF_CHW-1:0] ch;
  } adcf_req_t;

  // End of conversion from the analog core
  typedef struct packed
  {
    logic valid;
    logic [ADCF_CHW-1:0] ch;
    logic [ADCF_DW-1:0] data;
  } adcf_eoc_t;

  // Sequencer states, Gray coded along the scan path except the direct SCAN to DONE step
  typedef enum logic [1:0]
  {
    ADCF_ST_IDLE = 2'h0,
    ADCF_ST_SCAN = 2'h1,
    ADCF_ST_CONV = 2'h3,
    ADCF_ST_DONE = 2'h2
  } adcf_state_t;

endpackage

// ### hdl/adcf_chan_flags.sv
// Per-channel conversion-done and overrun flags
`timescale 1ns/1ps
module adcf_chan_flags
#(
  parameter int NCH = adcf_pkg::ADCF_NCH,
  parameter int CHW = adcf_pkg::ADCF_CHW
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic store,
  input wire logic [CHW-1:0] store_chan,
  input wire logic rd_chan,
  input wire logic [CHW-1:0] chan_sel,
  input wire logic rd_last,
  input wire logic [CHW-1:0] last_chan,
  input wire logic rd_stat,
  output logic [NCH-1:0] eoc_flags,
  output logic [NCH-1:0] channel_overrun_flag_flags,
  output logic [NCH-1:0] channel_overrun_flag_set
);
  import adcf_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      logic set_eoc;
      logic clr_eoc;
      // Only the read channel, or the channel behind the last result
      assign set_eoc = store && (store_chan == CHW'(i));
      assign clr_eoc = (rd_chan && (chan_sel == CHW'(i)))
        || (rd_last && (last_chan == CHW'(i)));
      assign channel_overrun_flag_set[i] = set_eoc && eoc_flags[i];

      // Done flag, a new result wins over a clearing read
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          eoc_flags[i] <= 1'b0;
        else if (set_eoc)
          eoc_flags[i] <= 1'b1;
        else if (clr_eoc)
          eoc_flags[i] <= 1'b0;
      end

      // Overrun flag, cleared by a status read unless set again
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          channel_overrun_flag_flags[i] <= 1'b0;
        else if (channel_overrun_flag_set[i])
          channel_overrun_flag_flags[i] <= 1'b1;
        else if (rd_stat)
          channel_overrun_flag_flags[i] <= 1'b0;
      end
    end
  endgenerate

endmodule

// ### hdl/adcf_status_core.sv
// Converter control: registers, sequencer, status flags and interrupt
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module adcf_status_core
#(
  parameter int NCH = adcf_pkg::ADCF_NCH,
  parameter int CHW = adcf_pkg::ADCF_CHW,
  parameter int DW = adcf_pkg::ADCF_DW
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [adcf_pkg::ADCF_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output adcf_pkg::adcf_req_t conv_req,
  input wire adcf_pkg::adcf_eoc_t conv_done,
  output logic low_power,
  output logic irq
);
  import adcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [NCH-1:0] chen_q;
  logic sleep_q;
  logic [DW-1:0] chan_res_q [NCH];
  logic [DW-1:0] last_res_q;
  logic [CHW-1:0] last_chan_q;
  logic data_ready_flag_q;
  logic general_overrun_flag_q;
  logic low_power_q;
  logic [ADCF_IRQ_W-1:0] irq_stat_q;
  logic [ADCF_IRQ_W-1:0] irq_mask_q;
  logic [ADCF_IRQ_W-1:0] irq_ev;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  adcf_state_t state_q;
  logic [CHW-1:0] ptr_q;
  adcf_req_t req_q;
  logic [NCH-1:0] eoc_q;
  logic [NCH-1:0] channel_overrun_flag_q;
  logic [NCH-1:0] channel_overrun_flag_set;
  logic start_wr;
  logic chen_wr;
  logic chdis_wr;
  logic [NCH-1:0] wmask;
  logic store;
  logic general_overrun_flag_set;
  logic rd_stat;
  logic rd_last;
  logic rd_irq;
  logic rd_chan;
  logic [ADCF_AW-1:0] chan_off;
  logic [CHW-1:0] chan_sel;
  logic ptr_last;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Write strobes per register
  assign start_wr = reg_wr && (reg_addr == ADCF_OFF_CTRL)
    && reg_wdata[ADCF_CTRL_START_BIT];
  assign chen_wr = reg_wr && (reg_addr == ADCF_OFF_CHEN);
  assign chdis_wr = reg_wr && (reg_addr == ADCF_OFF_CHDIS);
  assign wmask = reg_wdata[NCH-1:0];

  // Read strobes with side effects
  assign rd_stat = reg_rd && (reg_addr == ADCF_OFF_STAT);
  assign rd_last = reg_rd && (reg_addr == ADCF_OFF_LAST);
  assign rd_irq = reg_rd && (reg_addr == ADCF_OFF_IRQ_STAT);
  assign chan_off = reg_addr - ADCF_OFF_CHAN_BASE;
  assign chan_sel = chan_off[CHW+1:2];
  assign rd_chan = reg_rd && (reg_addr >= ADCF_OFF_CHAN_BASE)
    && (chan_off[ADCF_AW-1:CHW+2] == '0) && (chan_off[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Channel enable set, changed by enable and disable writes
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      chen_q <= ADCF_RST_CHEN;
    else if (chen_wr)
      chen_q <= chen_q | wmask;
    else if (chdis_wr)
      chen_q <= chen_q & ~wmask;
  end

  // Sleep setting
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      sleep_q <= ADCF_RST_SLEEP;
    else if (reg_wr && (reg_addr == ADCF_OFF_MODE))
      sleep_q <= reg_wdata[ADCF_MODE_SLEEP_BIT];
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_mask_q <= ADCF_RST_MASK;
    else if (reg_wr && (reg_addr == ADCF_OFF_IRQ_MASK))
      irq_mask_q <= reg_wdata[ADCF_IRQ_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Result storage

  // Store only if still enabled and not being disabled now
  assign store = conv_done.valid && chen_q[conv_done.ch]
    && !(chdis_wr && wmask[conv_done.ch]);

  // Per-channel results
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int k = 0; k < NCH; k++)
        chan_res_q[k] <= '0;
    end
    else if (store)
      chan_res_q[conv_done.ch] <= conv_done.data;
  end

  // Last converted result and its channel
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_res_q <= '0;
      last_chan_q <= '0;
    end
    else if (store)
    begin
      last_res_q <= conv_done.data;
      last_chan_q <= conv_done.ch;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  assign general_overrun_flag_set = store && data_ready_flag_q;

  // Data ready: set by a stored result, cleared by last-result read
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      data_ready_flag_q <= 1'b0;
    else if (store)
      data_ready_flag_q <= 1'b1;
    else if (rd_last)
      data_ready_flag_q <= 1'b0;
  end

  // General overrun, a new overrun wins over the status read
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      general_overrun_flag_q <= 1'b0;
    else if (general_overrun_flag_set)
      general_overrun_flag_q <= 1'b1;
    else if (rd_stat)
      general_overrun_flag_q <= 1'b0;
  end

  // Per-channel done and overrun flags
  adcf_chan_flags
  #(
    .NCH(NCH),
    .CHW(CHW)
  )
  u_flags
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .store(store),
    .store_chan(conv_done.ch),
    .rd_chan(rd_chan),
    .chan_sel(chan_sel),
    .rd_last(rd_last),
    .last_chan(last_chan_q),
    .rd_stat(rd_stat),
    .eoc_flags(eoc_q),
    .channel_overrun_flag_flags(channel_overrun_flag_q),
    .channel_overrun_flag_set(channel_overrun_flag_set)
  );

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  assign ptr_last = (ptr_q == CHW'(NCH - 1));

  // Scan of enabled channels, one request at a time
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ADCF_ST_IDLE;
      ptr_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ADCF_ST_IDLE:
        begin
          if (start_wr && (|chen_q))
          begin
            state_q <= ADCF_ST_SCAN;
            ptr_q <= '0;
          end
        end
        ADCF_ST_SCAN:
        begin
          if (chen_q[ptr_q])
            state_q <= ADCF_ST_CONV;
          else if (ptr_last)
            state_q <= ADCF_ST_DONE;
          else
            ptr_q <= ptr_q + 1'b1;
        end
        ADCF_ST_CONV:
        begin
          if (conv_done.valid)
          begin
            if (ptr_last)
              state_q <= ADCF_ST_DONE;
            else
            begin
              state_q <= ADCF_ST_SCAN;
              ptr_q <= ptr_q + 1'b1;
            end
          end
        end
        ADCF_ST_DONE:
          state_q <= ADCF_ST_IDLE;
      endcase
    end
  end

  // One-cycle request towards the analog core
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      req_q <= '0;
    else
    begin
      req_q.valid <= (state_q == ADCF_ST_SCAN) && chen_q[ptr_q];
      req_q.ch <= ptr_q;
    end
  end

  assign conv_req = req_q;

  // Low power entered at end of conversion, left on start
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      low_power_q <= 1'b0;
    else if (conv_done.valid && sleep_q)
      low_power_q <= 1'b1;
    else if (start_wr)
      low_power_q <= 1'b0;
  end

  assign low_power = low_power_q;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt

  // Events of this cycle
  always_comb
  begin
    irq_ev = '0;
    irq_ev[ADCF_EV_EOC] = store;
    irq_ev[ADCF_EV_GENERAL_OVERRUN_FLAG] = general_overrun_flag_set;
    irq_ev[ADCF_EV_CHANNEL_OVERRUN_FLAG] = |channel_overrun_flag_set;
    irq_ev[ADCF_EV_SEQ] = (state_q == ADCF_ST_DONE);
  end

  // Sticky events, cleared by reading them, new events win
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~{ADCF_IRQ_W{rd_irq}}) | irq_ev;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Read data

  // Read mux, unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    if (rd_chan)
      rdata_d[DW-1:0] = chan_res_q[chan_sel];
    else
    begin
      unique case (reg_addr)
        ADCF_OFF_MODE: rdata_d[ADCF_MODE_SLEEP_BIT] = sleep_q;
        ADCF_OFF_CHSR: rdata_d[NCH-1:0] = chen_q;
        ADCF_OFF_STAT:
        begin
          rdata_d[NCH-1:0] = eoc_q;
          rdata_d[ADCF_STAT_CHANNEL_OVERRUN_FLAG_LSB +: NCH] = channel_overrun_flag_q;
          rdata_d[ADCF_STAT_DATA_READY_FLAG_BIT] = data_ready_flag_q;
          rdata_d[ADCF_STAT_GENERAL_OVERRUN_FLAG_BIT] = general_overrun_flag_q;
          rdata_d[ADCF_STAT_LOWPWR_BIT] = low_power_q;
        end
        ADCF_OFF_LAST:
        begin
          rdata_d[DW-1:0] = last_res_q;
          rdata_d[ADCF_LAST_CHAN_LSB +: CHW] = last_chan_q;
        end
        ADCF_OFF_IRQ_STAT: rdata_d[ADCF_IRQ_W-1:0] = irq_stat_q;
        ADCF_OFF_IRQ_MASK: rdata_d[ADCF_IRQ_W-1:0] = irq_mask_q;
        default: rdata_d = '0;
      endcase
    end
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= '0;
    else if (reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= '0;
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_DATA_READY_FLAG_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    store |=> data_ready_flag_q)
    else $error("data ready not raised by stored result");

  AST_DATA_READY_FLAG_CHAN_KEEP: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_chan && data_ready_flag_q) |=> data_ready_flag_q)
    else $error("channel read changed data ready");

  AST_DATA_READY_FLAG_LAST_CLR: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_last && !store) |=> !data_ready_flag_q)
    else $error("last result read left data ready set");

  AST_NO_DATA_READY_FLAG_DISABLED: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (conv_done.valid && !store) |=> !$rose(data_ready_flag_q))
    else $error("unstored result raised data ready");

  AST_GENERAL_OVERRUN_FLAG_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (store && data_ready_flag_q) |=> general_overrun_flag_q)
    else $error("general overrun missed");

  AST_GENERAL_OVERRUN_FLAG_CLR: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_stat && !general_overrun_flag_set) |=> !general_overrun_flag_q)
    else $error("status read left general overrun set");

  AST_CHANNEL_OVERRUN_FLAG_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (store && eoc_q[conv_done.ch]) |=> channel_overrun_flag_q[$past(conv_done.ch)])
    else $error("channel overrun missed");

  AST_CHANNEL_OVERRUN_FLAG_CLR: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_stat && !(|channel_overrun_flag_set)) |=> (channel_overrun_flag_q == '0))
    else $error("status read left channel overrun set");

  AST_EOC_CLR_ONE: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_chan && !store) |=>
      (eoc_q == ($past(eoc_q) & ~(NCH'(1) << $past(chan_sel)))))
    else $error("channel read cleared wrong done flag");

  AST_EOC_NO_RISE: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !store |=> ((eoc_q & ~$past(eoc_q)) == '0))
    else $error("done flag rose without stored result");

  AST_START_REQ: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (start_wr && (state_q == ADCF_ST_IDLE) && (|chen_q))
      |-> ##[2:10] conv_req.valid)
    else $error("start write issued no conversion request");

  AST_SLEEP_ENTER: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (conv_done.valid && sleep_q) |=> low_power)
    else $error("low power not entered after conversion");

endmodule

// ### bench/adcf_core_model.sv
// Behavioural analog core answering each conversion request once
`timescale 1ns/1ps
module adcf_core_model
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire adcf_pkg::adcf_req_t req,
  input wire logic [7:0] lat,
  output adcf_pkg::adcf_eoc_t done
);
  import adcf_pkg::*;
  logic [7:0] cnt_q;
  logic [ADCF_CHW-1:0] ch_q;
  logic vld_q;
  logic [ADCF_DW-1:0] lfsr_q;
  // Count the conversion time down, one answer for each request
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 8'h00;
      ch_q <= 3'h0;
      vld_q <= 1'b0;
      lfsr_q <= 10'h001;
    end
    else
    begin
      lfsr_q <= {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
      vld_q <= (cnt_q == 8'h01);
      if (req.valid)
      begin
        cnt_q <= lat;
        ch_q <= req.ch;
      end
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
  // Data moves every cycle, channel inverted while no answer stands
  assign done = '{valid: vld_q, ch: vld_q ? ch_q : ~ch_q, data: lfsr_q};
endmodule

// ### bench/adcf_status_core_bench.sv
// Self-checking bench of the converter status-flag block
`timescale 1ns/1ps
module adcf_status_core_bench;
  import adcf_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADCF_AW-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  adcf_req_t conv_req;
  adcf_eoc_t conv_done;
  logic low_power;
  logic irq;
  logic [7:0] lat = 8'h04;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 92;
  int m_prev;
  logic [7:0] m_chen, m_done, m_channel_overrun_flag, o;
  logic m_data_ready_flag, m_general_overrun_flag, m_lowp, m_sleep, st, ov, gv, lp;
  logic [3:0] m_ist, m_mask, m_sq;
  logic [9:0] m_res [8];
  logic [9:0] m_lres;
  logic [2:0] m_lch, c;
  logic [31:0] m_rd;

  always #2.5 ref_clk = ~ref_clk;

  adcf_status_core i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_req(conv_req),
    .conv_done(conv_done), .low_power(low_power), .irq(irq));

  adcf_core_model i_core (.ref_clk(ref_clk), .rst_b(rst_b),
    .req(conv_req), .lat(lat), .done(conv_done));

  //////////////////////////////////////////////////////////////////////////
  // Reference model of registers and flags, moved at every edge
  always @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      {m_chen, m_done, m_channel_overrun_flag, m_data_ready_flag, m_general_overrun_flag, m_lowp, m_sleep} = '0;
      {m_sq, m_ist, m_mask, m_lres, m_lch, m_rd} = '0;
      m_res = '{default: 10'h000};
    end
    else
    begin
      c = conv_done.ch;
      o = reg_addr - ADCF_OFF_CHAN_BASE;
      st = conv_done.valid && m_chen[c] && !(reg_wr &&
        reg_addr == ADCF_OFF_CHDIS && reg_wdata[c]);
      ov = st && m_done[c];
      gv = st && m_data_ready_flag;
      lp = conv_done.valid && m_sleep;
      m_rd = 32'h0;
      if (reg_rd)
        case (reg_addr)
          ADCF_OFF_MODE: m_rd = {31'h0, m_sleep};
          ADCF_OFF_CHSR: m_rd = {24'h0, m_chen};
          ADCF_OFF_STAT:
            m_rd = {13'h0, m_lowp, m_general_overrun_flag, m_data_ready_flag, m_channel_overrun_flag, m_done};
          ADCF_OFF_LAST: m_rd = {17'h0, m_lch, 2'h0, m_lres};
          ADCF_OFF_IRQ_STAT: m_rd = {28'h0, m_ist};
          ADCF_OFF_IRQ_MASK: m_rd = {28'h0, m_mask};
          default:
            if (o < 8'h20 && o[1:0] == 2'h0)
              m_rd = {22'h0, m_res[o[4:2]]};
        endcase
      if (reg_rd && reg_addr == ADCF_OFF_STAT)
        {m_channel_overrun_flag, m_general_overrun_flag} = '0;
      if (reg_rd && reg_addr == ADCF_OFF_LAST)
        {m_data_ready_flag, m_done[m_lch]} = 2'h0;
      if (reg_rd && o < 8'h20 && o[1:0] == 2'h0)
        m_done[o[4:2]] = 1'b0;
      if (reg_rd && reg_addr == ADCF_OFF_IRQ_STAT)
        m_ist = 4'h0;
      if (reg_wr)
        case (reg_addr)
          ADCF_OFF_CTRL: if (reg_wdata[0]) {m_lowp, m_prev} = {1'b0, -32'sd1};
          ADCF_OFF_MODE: m_sleep = reg_wdata[0];
          ADCF_OFF_CHEN: m_chen = m_chen | reg_wdata[7:0];
          ADCF_OFF_CHDIS: m_chen = m_chen & ~reg_wdata[7:0];
          ADCF_OFF_IRQ_MASK: m_mask = reg_wdata[3:0];
          default: ;
        endcase
      if (st)
        {m_done[c], m_data_ready_flag, m_res[c], m_lres, m_lch} =
          {2'h3, conv_done.data, conv_done.data, c};
      if (ov)
        m_channel_overrun_flag[c] = 1'b1;
      if (gv)
        m_general_overrun_flag = 1'b1;
      if (lp)
        m_lowp = 1'b1;
      // Sequence end waits for the scan to run past the top channel
      m_ist = m_ist | {m_sq == 4'h1, ov, gv, st};
      if (m_sq != 4'h0)
        m_sq = m_sq - 4'h1;
      if (conv_done.valid && ((m_chen >> c) >> 1) == 8'h00)
        m_sq = 4'(8 - c);
    end

  // Compare the design with the model half a cycle after each edge
  always @(negedge ref_clk)
    if (rst_b)
    begin
      chk(reg_rdata, m_rd);
      chk({30'h0, irq, low_power}, {30'h0, |(m_ist & m_mask), m_lowp});
      if (conv_req.valid)
      begin
        chk({31'h0, m_chen[conv_req.ch] && int'(conv_req.ch) > m_prev},
          32'h1);
        m_prev = conv_req.ch;
      end
    end

  //////////////////////////////////////////////////////////////////////////
  // Count a comparison, report a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One register access: write when w is high, otherwise read
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // Read every place of the map, holes included
  task automatic dump();
    for (int a = 0; a < 'h50; a += 4)
      op(1'b0, a[7:0], 32'h0);
  endtask

  // Bounded wait for the next conversion request
  task automatic wait_req(output logic [2:0] ch);
    int n;
    n = 0;
    do
      @(negedge ref_clk);
    while (conv_req.valid !== 1'b1 && ++n < 200);
    if (n >= 200)
    begin
      err_count++;
      end_of_test();
    end
    ch = conv_req.ch;
  endtask

  // One scan with an action landing on the cycle of each result
  task automatic scan(input logic [7:0] en, input logic [31:0] acts);
    logic [2:0] ch;
    logic [2:0] a;
    op(1'b1, ADCF_OFF_CHDIS, 32'hff);
    op(1'b1, ADCF_OFF_CHEN, {24'h0, en});
    op(1'b1, ADCF_OFF_CTRL, 32'h1);
    for (int i = 0; i < $countones(en); i++)
    begin
      wait_req(ch);
      a = acts[4*i +: 3];
      if (a >= 3'h5)
        op(1'b1, ADCF_OFF_CHDIS, 32'h1 << ch);
      repeat (lat - (a >= 3'h5 ? 2 : 0)) @(posedge ref_clk);
      case (a)
        3'h1, 3'h5: op(1'b0, ADCF_OFF_CHAN_BASE + {ch ^ 3'h2, 2'h0},
          32'h0);
        3'h2: op(1'b0, ADCF_OFF_STAT, 32'h0);
        3'h3, 3'h6: op(1'b0, ADCF_OFF_LAST, 32'h0);
        3'h4: op(1'b1, ADCF_OFF_CHDIS, 32'h1 << (ch - 3'h1));
        default: ;
      endcase
    end
    repeat (lat + 8) @(posedge ref_clk);
  endtask

  // Verdict and end of the run
  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    op(1'b1, ADCF_OFF_CHSR, 32'hff);
    dump();
    // Random channel sets, prompt and slow answers, results left unread
    repeat (3)
    begin
      lat <= 8'(2 + {$random(seed)} % 20);
      scan(8'h01 | 8'($random(seed)), 32'h0);
      op(1'b1, ADCF_OFF_IRQ_MASK, 32'($random(seed)));
    end
    // Reads, status reads and disables on the cycle of a result
    lat <= 8'h06;
    op(1'b1, ADCF_OFF_IRQ_MASK, 32'hf);
    scan(8'h0f, 32'h4321);
    scan(8'h0f, 32'h5215);
    op(1'b1, ADCF_OFF_MODE, 32'h1);
    scan(8'h1f, 32'h63153);
    op(1'b1, ADCF_OFF_MODE, 32'h0);
    dump();
    // Second reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    dump();
    end_of_test();
  end
endmodule
